// ### rtl/rtc_flag_pkg.sv
/*
 * constants and carriers for the rtc carry/alarm flag register.
 * assumes a single 40 MHz clock domain and a plain strobe register port.
 */
package rtc_flag_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W          = 4;
    localparam logic [3:0]  RTC_FLAG_CONTROL_OFS = 4'h0;
    localparam logic [7:0]  RTC_FLAG_CONTROL_RST = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

    // ------------------------------------------------------------
    // field positions of rtc_flag_control
    // ------------------------------------------------------------
    localparam int unsigned CARRY_FLAG_BIT       = 7;
    localparam int unsigned CARRY_IRQ_ENABLE_BIT = 4;
    localparam int unsigned ALARM_IRQ_ENABLE_BIT = 3;
    localparam int unsigned ALARM_MATCH_FLAG_BIT = 0;
    localparam logic [7:0]  RESERVED_MASK        = 8'h66;

    // ------------------------------------------------------------
    // alarm field layout: bit 7 is the compare enable
    // ------------------------------------------------------------
    localparam int unsigned FIELD_ENABLE_BIT = 7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  seconds;
        logic [7:0]  minutes;
        logic [7:0]  hours;
        logic [7:0]  weekday;
        logic [7:0]  date;
        logic [7:0]  month;
        logic [15:0] year;
    } clock_time_t;

    typedef struct packed {
        logic [7:0]  seconds;
        logic [7:0]  minutes;
        logic [7:0]  hours;
        logic [7:0]  weekday;
        logic [7:0]  date;
        logic [7:0]  month;
        logic [15:0] year;
        logic        yearAlarmEnable;
    } alarm_set_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              write;
        logic              read;
    } reg_req_t;

endpackage : rtc_flag_pkg

// ### rtl/rtc_carry_alarm_flags.sv
/*
 * flag and interrupt-enable register of the rtc: carry flag, alarm
 * flag and their two interrupt enables, with the alarm comparator.
 * assumes the counter block pulses counterReadCarry for one cycle when
 * a subsecond or seconds counter read coincides with a carry, and that
 * time and alarm inputs are synchronous to sys_clk.
 */
// Functional notes
// - an 8-bit flag/control register is cleared to zero by every reset.
// - standby does not touch any bit of the register.
// - a counter read during a carry sets the carry flag in bit 7.
// - writing 0 clears the carry flag and writing 1 sets it.
// - bits 6, 5, 2 and 1 read as zero and should be written as zero.
// - carry interrupt is requested only when bit 7 and bit 4 are both 1.
// - alarm interrupt is requested only when bit 0 and bit 3 are both 1.
// - the alarm flag sets when all enabled alarm fields match the time.
// - writing 0 clears the alarm flag and writing 1 leaves it alone.
// - each field compares only when its enable (or year enable) is 1.
`timescale 1ns/10ps
`default_nettype none

module rtc_carry_alarm_flags (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     nrst,
    // register port
    input  wire rtc_flag_pkg::reg_req_t   regReq,
    output var  logic [7:0]               regRdata,
    // counter block
    input  wire logic                     counterReadCarry,
    input  wire rtc_flag_pkg::clock_time_t clockTime,
    // alarm settings
    input  wire rtc_flag_pkg::alarm_set_t alarmSet,
    // interrupt requests
    output var  logic                     carryIrq,
    output var  logic                     alarmIrq
);

    // ------------------------------------------------------------
    // alarm comparison
    // ------------------------------------------------------------
    function automatic logic fieldHit(input logic [7:0] alarm,
                                      input logic [7:0] count);
        fieldHit = !alarm[rtc_flag_pkg::FIELD_ENABLE_BIT] ||
                   (alarm[6:0] == count[6:0]);
    endfunction : fieldHit

    logic anyEnabled;
    logic matchNow;
    logic matchPrev_reg;
    logic matchRise;

    assign anyEnabled = alarmSet.seconds[7] | alarmSet.minutes[7] |
                        alarmSet.hours[7]   | alarmSet.weekday[7] |
                        alarmSet.date[7]    | alarmSet.month[7]   |
                        alarmSet.yearAlarmEnable;

    // disabled fields always hit; nothing enabled means no alarm
    assign matchNow = anyEnabled                                        &&
        fieldHit(alarmSet.seconds, clockTime.seconds)                    &&
        fieldHit(alarmSet.minutes, clockTime.minutes)                    &&
        fieldHit(alarmSet.hours,   clockTime.hours)                      &&
        fieldHit(alarmSet.weekday, clockTime.weekday)                    &&
        fieldHit(alarmSet.date,    clockTime.date)                       &&
        fieldHit(alarmSet.month,   clockTime.month)                      &&
        (!alarmSet.yearAlarmEnable ||
         (alarmSet.year == clockTime.year));

    // the flag sets once per match so software can clear it mid-match
    assign matchRise = matchNow && !matchPrev_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            matchPrev_reg <= 1'b0;
        end else begin
            matchPrev_reg <= matchNow;
        end
    end

    // ------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------
    logic hit;
    logic wrCtl;
    logic carryFlag_reg;
    logic carryFlag_next;
    logic carryIe_reg;
    logic alarmIe_reg;
    logic alarmFlag_reg;
    logic alarmFlag_next;

    assign hit   = regReq.addr == rtc_flag_pkg::RTC_FLAG_CONTROL_OFS;
    assign wrCtl = regReq.write && hit;

    // hardware set wins over a write of zero
    always_comb begin
        carryFlag_next = carryFlag_reg;
        if (wrCtl) begin
            carryFlag_next =
                regReq.wdata[rtc_flag_pkg::CARRY_FLAG_BIT];
        end
        if (counterReadCarry) begin
            carryFlag_next = 1'b1;
        end
    end

    always_comb begin
        alarmFlag_next = alarmFlag_reg;
        if (wrCtl &&
            !regReq.wdata[rtc_flag_pkg::ALARM_MATCH_FLAG_BIT]) begin
            alarmFlag_next = 1'b0;
        end
        if (matchRise) begin
            alarmFlag_next = 1'b1;
        end
    end

    // no standby input: the register simply holds its contents
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            carryFlag_reg <= rtc_flag_pkg::RTC_FLAG_CONTROL_RST[
                rtc_flag_pkg::CARRY_FLAG_BIT];
            alarmFlag_reg <= rtc_flag_pkg::RTC_FLAG_CONTROL_RST[
                rtc_flag_pkg::ALARM_MATCH_FLAG_BIT];
        end else begin
            carryFlag_reg <= carryFlag_next;
            alarmFlag_reg <= alarmFlag_next;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            carryIe_reg <= rtc_flag_pkg::RTC_FLAG_CONTROL_RST[
                rtc_flag_pkg::CARRY_IRQ_ENABLE_BIT];
            alarmIe_reg <= rtc_flag_pkg::RTC_FLAG_CONTROL_RST[
                rtc_flag_pkg::ALARM_IRQ_ENABLE_BIT];
        end else if (wrCtl) begin
            carryIe_reg <=
                regReq.wdata[rtc_flag_pkg::CARRY_IRQ_ENABLE_BIT];
            alarmIe_reg <=
                regReq.wdata[rtc_flag_pkg::ALARM_IRQ_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // read data and interrupt requests
    // ------------------------------------------------------------
    logic [7:0] ctlView;

    always_comb begin
        ctlView = 8'h00;
        ctlView[rtc_flag_pkg::CARRY_FLAG_BIT]       = carryFlag_reg;
        ctlView[rtc_flag_pkg::CARRY_IRQ_ENABLE_BIT] = carryIe_reg;
        ctlView[rtc_flag_pkg::ALARM_IRQ_ENABLE_BIT] = alarmIe_reg;
        ctlView[rtc_flag_pkg::ALARM_MATCH_FLAG_BIT] = alarmFlag_reg;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else if (regReq.read) begin
            regRdata <= hit ? ctlView : rtc_flag_pkg::UNMAPPED_READ;
        end else begin
            regRdata <= 8'h00;
        end
    end

    // requests follow the next flag/enable values so they track the
    // register cycle for cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            carryIrq <= 1'b0;
            alarmIrq <= 1'b0;
        end else begin
            carryIrq <= carryFlag_next &&
                (wrCtl ? regReq.wdata[rtc_flag_pkg::CARRY_IRQ_ENABLE_BIT]
                       : carryIe_reg);
            alarmIrq <= alarmFlag_next &&
                (wrCtl ? regReq.wdata[rtc_flag_pkg::ALARM_IRQ_ENABLE_BIT]
                       : alarmIe_reg);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!nrst)
        (regRdata & rtc_flag_pkg::RESERVED_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read as non-zero");

    property p_carry_set;
        @(posedge sys_clk) disable iff (!nrst)
        counterReadCarry |=> carryFlag_reg ##0 carryIrq == carryIe_reg;
    endproperty
    a_carry_set: assert property (p_carry_set)
        else $error("carry flag not set by carry read");

    property p_carry_write;
        @(posedge sys_clk) disable iff (!nrst)
        wrCtl && !counterReadCarry |=>
            carryFlag_reg == $past(regReq.wdata[7]);
    endproperty
    a_carry_write: assert property (p_carry_write)
        else $error("carry flag does not follow written value");

    property p_alarm_write_one;
        @(posedge sys_clk) disable iff (!nrst)
        wrCtl && regReq.wdata[0] && !matchRise |=> $stable(alarmFlag_reg);
    endproperty
    a_alarm_write_one: assert property (p_alarm_write_one)
        else $error("writing one changed the alarm flag");

    property p_alarm_clear;
        @(posedge sys_clk) disable iff (!nrst)
        wrCtl && !regReq.wdata[0] && !matchRise |=> !alarmFlag_reg;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("writing zero did not clear the alarm flag");

    property p_alarm_cause;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(alarmFlag_reg) |-> $past(matchNow) && !$past(matchPrev_reg);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause)
        else $error("alarm flag set without a new match");

    property p_alarm_set;
        @(posedge sys_clk) disable iff (!nrst)
        matchRise |=> alarmFlag_reg;
    endproperty
    a_alarm_set: assert property (p_alarm_set)
        else $error("alarm match did not set the flag");

    property p_carry_irq;
        @(posedge sys_clk) disable iff (!nrst)
        carryIrq == (carryFlag_reg && carryIe_reg);
    endproperty
    a_carry_irq: assert property (p_carry_irq)
        else $error("carry request disagrees with flag and enable");

    property p_alarm_irq;
        @(posedge sys_clk) disable iff (!nrst)
        alarmIrq == (alarmFlag_reg && alarmIe_reg);
    endproperty
    a_alarm_irq: assert property (p_alarm_irq)
        else $error("alarm request disagrees with flag and enable");

    property p_readback;
        @(posedge sys_clk) disable iff (!nrst)
        regReq.read && hit && !wrCtl |=> regRdata == $past(ctlView);
    endproperty
    a_readback: assert property (p_readback)
        else $error("read data does not show the register");

    c_carry_irq: cover property (@(posedge sys_clk) disable iff (!nrst)
        counterReadCarry && carryIe_reg ##1 carryIrq);
    c_alarm_irq: cover property (@(posedge sys_clk) disable iff (!nrst)
        matchRise && alarmIe_reg ##1 alarmIrq);
    c_alarm_clear: cover property (@(posedge sys_clk) disable iff (!nrst)
        alarmFlag_reg && wrCtl && !regReq.wdata[0] ##1 !alarmFlag_reg);
    c_set_beats_clear: cover property (@(posedge sys_clk)
        disable iff (!nrst) counterReadCarry && wrCtl && !regReq.wdata[7]);

endmodule : rtc_carry_alarm_flags

`default_nettype wire

// ### tb/tb_top.sv
/*
 * self-checking bench for rtc_carry_alarm_flags: a cycle model of the
 * flag register is compared with read data and both interrupt requests.
 * assumes the design package rtc_flag_pkg and a single sys_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                      sys_clk;
    logic                      nrst;
    rtc_flag_pkg::reg_req_t    regReq;
    logic [7:0]                regRdata;
    logic                      counterReadCarry;
    rtc_flag_pkg::clock_time_t clockTime;
    rtc_flag_pkg::alarm_set_t  alarmSet;
    logic                      carryIrq;
    logic                      alarmIrq;
    int                        failures;
    int                        testsRun;
    logic                      mCf, mCie, mAie, mAf, mPrev, mHit;
    logic [7:0]                mRd;

    rtc_carry_alarm_flags DUT (
        .sys_clk          (sys_clk),
        .nrst             (nrst),
        .regReq           (regReq),
        .regRdata         (regRdata),
        .counterReadCarry (counterReadCarry),
        .clockTime        (clockTime),
        .alarmSet         (alarmSet),
        .carryIrq         (carryIrq),
        .alarmIrq         (alarmIrq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    function automatic logic match(input rtc_flag_pkg::clock_time_t ct,
                                   input rtc_flag_pkg::alarm_set_t as);
        logic       any;
        logic       ok;
        logic [7:0] a;
        logic [7:0] c;
        any = as.yearAlarmEnable;
        ok  = !as.yearAlarmEnable || (as.year === ct.year);
        for (int i = 0; i < 6; i++) begin
            a = as[64-8*i -: 8];
            c = ct[63-8*i -: 8];
            if (a[7]) begin
                any = 1'b1;
                ok  = ok && (a[6:0] === c[6:0]);
            end
        end
        return any && ok;
    endfunction : match

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {mCf, mCie, mAie, mAf, mPrev, mRd} = '0;
        end else begin
            mRd  = (regReq.read && regReq.addr == 4'h0) ?
                   {mCf, 2'b00, mCie, mAie, 2'b00, mAf} : 8'h00;
            mHit = match(clockTime, alarmSet);
            if (regReq.write && regReq.addr == 4'h0) begin
                mCf  = regReq.wdata[7];
                mCie = regReq.wdata[4];
                mAie = regReq.wdata[3];
                if (!regReq.wdata[0]) mAf = 1'b0;
            end
            if (counterReadCarry) mCf = 1'b1;
            if (mHit && !mPrev) mAf = 1'b1;
            mPrev = mHit;
        end
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (exp !== got) begin
            failures++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : cmp

    task automatic complete_run();
        $display("failures=%0d comparisons=%0d", failures, testsRun);
        if (failures == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    always @(negedge sys_clk) begin
        cmp(mRd, regRdata);
        cmp({7'h00, mCf & mCie}, {7'h00, carryIrq});
        cmp({7'h00, mAf & mAie}, {7'h00, alarmIrq});
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        complete_run();
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    function automatic rtc_flag_pkg::reg_req_t req(input logic [3:0] ad,
        input logic [7:0] d, input logic w, input logic r);
        rtc_flag_pkg::reg_req_t q;
        q.addr  = ad;
        q.wdata = d;
        q.write = w;
        q.read  = r;
        return q;
    endfunction : req

    task automatic cyc(input rtc_flag_pkg::reg_req_t r, input logic c);
        @(posedge sys_clk);
        regReq           <= r;
        counterReadCarry <= c;
    endtask : cyc

    task automatic do_reset();
        @(posedge sys_clk);
        nrst <= 1'b0;
        regReq <= '0;
        counterReadCarry <= 1'b0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
    endtask : do_reset

    initial begin
        logic [63:0] t;
        logic [64:0] a;
        int          k;
        failures = 0;
        testsRun = 0;
        nrst = 1'b0;
        regReq = '0;
        counterReadCarry = 1'b0;
        clockTime = '0;
        alarmSet = '0;
        void'($urandom(32'h282a6aa3));
        do_reset();
        cyc(req(4'h0, 8'h00, 1'b1, 1'b0), 1'b0);
        cyc(req(4'h0, 8'h00, 1'b0, 1'b1), 1'b0);
        for (int n = 0; n < 300; n++) begin
            k = $urandom_range(0, 2);
            cyc(req(($urandom_range(0, 3) == 0) ? 4'($urandom) : 4'h0,
                8'($urandom) & ~rtc_flag_pkg::RESERVED_MASK,
                k == 1, k == 2),
                $urandom_range(0, 3) == 0);
        end
        for (int f = 0; f < 8; f++) begin
            t = {$urandom, $urandom};
            a = {t ^ 64'h0101010101010101, 1'b0};
            for (int i = 0; i < 6; i++) begin
                a[64-8*i] = (i == f);
                if (i == f) a[63-8*i -: 7] = t[62-8*i -: 7];
            end
            if (f == 6) begin
                a[16:0] = {t[15:0], 1'b1};
            end
            cyc(req(4'h0, 8'h08, 1'b1, 1'b0), 1'b0);
            cyc('0, 1'b0);
            clockTime <= t;
            alarmSet  <= a;
            cyc(req(4'h0, 8'h09, 1'b1, 1'b0), 1'b0);
            cyc(req(4'h0, 8'h00, 1'b0, 1'b1), 1'b0);
            cyc(req(4'h0, 8'h08, 1'b1, 1'b0), 1'b0);
            cyc('0, 1'b0);
            repeat (20) @(posedge sys_clk);
            cyc(req(4'h0, 8'h00, 1'b0, 1'b1), 1'b0);
            clockTime <= t ^ 64'h0101010101010101;
            cyc(req(4'h0, 8'h00, 1'b0, 1'b1), 1'b0);
            cyc('0, 1'b0);
        end
        // carry event together with a write of zero: the set wins
        cyc(req(4'h0, 8'h00, 1'b1, 1'b0), 1'b1);
        cyc(req(4'h0, 8'h00, 1'b0, 1'b1), 1'b0);
        // carry seen: read again before trusting any value
        cyc(req(4'h0, 8'h00, 1'b0, 1'b1), 1'b0);
        cyc(req(4'h0, 8'h98, 1'b1, 1'b0), 1'b0);
        cyc(req(4'h0, 8'h00, 1'b0, 1'b1), 1'b0);
        cyc('0, 1'b0);
        do_reset();
        cyc(req(4'h0, 8'h00, 1'b0, 1'b1), 1'b0);
        cyc('0, 1'b0);
        repeat (3) @(posedge sys_clk);
        complete_run();
    end

endmodule : tb_top

`default_nettype wire
